/* inc/tcs_pkg.sv */
// Constants, types and register map of the temperature conversion sequencer
package tcs_pkg;

  // ----------------------------------------------------------------
  // Register pointers
  // ----------------------------------------------------------------
  localparam logic [7:0] PTR_CFG1_RD       = 8'h03;
  localparam logic [7:0] PTR_CFG1_WR       = 8'h09;
  localparam logic [7:0] PTR_RATE_RD       = 8'h04;
  localparam logic [7:0] PTR_RATE_WR       = 8'h0a;
  localparam logic [7:0] PTR_ONESHOT       = 8'h0f;
  localparam logic [7:0] PTR_NADJ_SINGLE   = 8'h18;
  localparam logic [7:0] PTR_CHCFG_SINGLE  = 8'h1a;
  localparam logic [7:0] PTR_NADJ_CH1      = 8'h27;
  localparam logic [7:0] PTR_NADJ_CH2      = 8'h28;
  localparam logic [7:0] PTR_CHCFG_DUAL    = 8'h3f;
  localparam logic [7:0] PTR_BETA_CH1      = 8'h4b;
  localparam logic [7:0] PTR_BETA_CH2      = 8'h4c;

  // ----------------------------------------------------------------
  // Reset values, write masks and field positions
  // ----------------------------------------------------------------
  localparam logic [7:0] CFG1_RST          = 8'h00;
  localparam logic [7:0] CFG1_WMASK        = 8'he4;
  localparam logic [7:0] RATE_RST          = 8'h07;
  localparam logic [7:0] RATE_FAST_MIN     = 8'h07;
  localparam logic [2:0] RATE_SLOW_SHIFT   = 3'h6;
  localparam logic [7:0] CHCFG_RST_SINGLE  = 8'h1c;
  localparam logic [7:0] CHCFG_RST_DUAL    = 8'h3c;
  localparam logic [7:0] NADJ_RST          = 8'h00;
  localparam logic [3:0] BETA_RST          = 4'h7;
  localparam logic [3:0] BETA_MANUAL_OFF   = 4'h7;
  localparam logic [3:0] BETA_DIODE_RD     = 4'hf;
  localparam int         BIT_RC            = 2;
  localparam int         BIT_LEN           = 3;
  localparam int         BIT_REN1          = 4;
  localparam int         BIT_REMOTE2_CHAN_EN          = 5;
  localparam int         BIT_SD            = 6;

  // ----------------------------------------------------------------
  // Non-ideality arithmetic, base factor in thousandths
  // ----------------------------------------------------------------
  localparam int          NI_BASE_DIODE    = 1008;
  localparam int          NI_BASE_GC       = 1000;
  localparam int          NI_SCALE         = 300;
  localparam logic [18:0] NI_NUM_DIODE     = 19'(NI_BASE_DIODE * NI_SCALE);
  localparam logic [18:0] NI_NUM_GC        = 19'(NI_BASE_GC * NI_SCALE);
  localparam logic [9:0]  NI_DEN_RST       = 10'(NI_SCALE);

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_HZ          = 100_000_000;
  localparam int CYC_PER_MS      = CLK_HZ / 1000;
  localparam int CONV_AUTO_MS    = 126;
  localparam int CONV_MANUAL_MS  = 93;
  localparam int CONV_LOCAL_MS   = 93;
  localparam int PERIOD_FAST_MS  = 250;
  localparam int CONV_AUTO_CYC   = CONV_AUTO_MS * CYC_PER_MS;
  localparam int CONV_MANUAL_CYC = CONV_MANUAL_MS * CYC_PER_MS;
  localparam int CONV_LOCAL_CYC  = CONV_LOCAL_MS * CYC_PER_MS;
  localparam int PERIOD_FAST_CYC = PERIOD_FAST_MS * CYC_PER_MS;

  // ----------------------------------------------------------------
  // Sequencer states and channel codes
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    S_SHUT  = 3'h0,
    S_LOCAL = 3'h1,
    S_REM1  = 3'h3,
    S_REM2  = 3'h2,
    S_WAIT  = 3'h6
  } tcs_state_e;

  localparam logic [1:0] CH_LOCAL = 2'h0;
  localparam logic [1:0] CH_REM1  = 2'h1;
  localparam logic [1:0] CH_REM2  = 2'h2;

endpackage : tcs_pkg

/* verilog/tcs_chan_comp.sv */
// Per-remote-channel beta compensation and non-ideality unit
`timescale 1ns/100ps
module tcs_chan_comp (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register writes
  input  wire logic        beta_wr_i,
  input  wire logic        adj_wr_i,
  input  wire logic [7:0]  wdata_i,
  // Conversion start and detection result
  input  wire logic        start_i,
  input  wire logic        det_diode_i,
  input  wire logic [2:0]  det_range_i,
  // Readback and compensation outputs
  output logic      [3:0]  beta_rd_o,
  output logic      [7:0]  adj_o,
  output logic             long_conv_o,
  output logic      [18:0] ni_num_o,
  output logic      [9:0]  ni_den_o
);
  import tcs_pkg::*;

  typedef struct packed {
    logic [3:0]  beta_set;
    logic [3:0]  beta_rd;
    logic [7:0]  adj;
    logic [18:0] num;
    logic [9:0]  den;
  } tcs_comp_s;

  tcs_comp_s st_r;
  tcs_comp_s st_nxt;
  logic signed [10:0] den_full;

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt   = st_r;
    if (beta_wr_i) begin
      st_nxt.beta_set = wdata_i[3:0];
      st_nxt.beta_rd  = wdata_i[3:0];
    end
    if (adj_wr_i) begin
      st_nxt.adj = wdata_i;
    end
    // Denominator follows the adjust byte in the same cycle
    den_full   = 11'(NI_SCALE) - {{3{st_nxt.adj[7]}}, st_nxt.adj};
    st_nxt.den = den_full[9:0];
    if (start_i) begin
      if (st_r.beta_set[3]) begin
        if (det_diode_i) begin
          st_nxt.beta_rd = BETA_DIODE_RD;
          st_nxt.num     = NI_NUM_DIODE;
        end else begin
          st_nxt.beta_rd = {1'b1, det_range_i};
          st_nxt.num     = NI_NUM_GC;
        end
      end else if (st_r.beta_set == BETA_MANUAL_OFF) begin
        st_nxt.num = NI_NUM_DIODE;
      end else begin
        st_nxt.num = NI_NUM_GC;
      end
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{beta_set: BETA_RST, beta_rd: BETA_RST, adj: NADJ_RST,
                num: NI_NUM_DIODE, den: NI_DEN_RST};
    end else begin
      st_r <= st_nxt;
    end
  end

  // Long conversion only for auto mode with a ground-collector sensor
  assign long_conv_o = st_r.beta_set[3] & ~det_diode_i;
  assign beta_rd_o   = st_r.beta_rd;
  assign adj_o       = st_r.adj;
  assign ni_num_o    = st_r.num;
  assign ni_den_o    = st_r.den;

endmodule // tcs_chan_comp

/* verilog/tcs_top.sv */
// Temperature conversion sequencer: registers, channel order, rate and shutdown
`timescale 1ns/100ps
module tcs_top #(
  parameter bit          DUAL_REMOTE = 1'b0,
  parameter int unsigned CONV_LOCAL  = tcs_pkg::CONV_LOCAL_CYC,
  parameter int unsigned CONV_AUTO   = tcs_pkg::CONV_AUTO_CYC,
  parameter int unsigned CONV_MANUAL = tcs_pkg::CONV_MANUAL_CYC,
  parameter int unsigned PERIOD_FAST = tcs_pkg::PERIOD_FAST_CYC
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Register port
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  input  wire logic [7:0]  reg_ptr_i,
  input  wire logic [7:0]  reg_wdata_i,
  output logic      [7:0]  reg_rdata_o,
  output logic             reg_rvalid_o,
  // Front-end detection results
  input  wire logic        det_diode1_i,
  input  wire logic [2:0]  det_range1_i,
  input  wire logic        det_diode2_i,
  input  wire logic [2:0]  det_range2_i,
  // Conversion control
  output logic             conv_start_o,
  output logic             conv_done_o,
  output logic             conv_abort_o,
  output logic             conv_busy_o,
  output logic      [1:0]  conv_chan_o,
  output logic             series_res_en_o,
  output logic             shutdown_o,
  // Compensation for the front end
  output logic      [18:0] ni_num1_o,
  output logic      [9:0]  ni_den1_o,
  output logic      [18:0] ni_num2_o,
  output logic      [9:0]  ni_den2_o
);
  import tcs_pkg::*;

  localparam logic [7:0] PTR_CHCFG  = DUAL_REMOTE ? PTR_CHCFG_DUAL : PTR_CHCFG_SINGLE;
  localparam logic [7:0] CHCFG_RST  = DUAL_REMOTE ? CHCFG_RST_DUAL : CHCFG_RST_SINGLE;
  localparam logic [7:0] PTR_NADJ1  = DUAL_REMOTE ? PTR_NADJ_CH1 : PTR_NADJ_SINGLE;

  typedef struct packed {
    logic [7:0]  cfg1;
    logic [7:0]  chcfg;
    logic [7:0]  rate;
    tcs_state_e  state;
    logic        oneshot;
    logic [31:0] timer;
    logic [31:0] period;
    logic        start;
    logic        done;
    logic        abort;
    logic        busy;
    logic [1:0]  chan;
    logic [7:0]  rdata;
    logic        rvalid;
  } tcs_seq_s;

  tcs_seq_s   st_r;
  tcs_seq_s   st_nxt;
  logic [2:0] chan_en;
  logic       sd_set_wr;
  logic       oneshot_wr;
  logic       go;
  logic       pass_end;
  tcs_state_e tgt;
  logic [31:0] period_len;
  logic [3:0] beta_rd1;
  logic [3:0] beta_rd2;
  logic [7:0] adj1;
  logic [7:0] adj2;
  logic       long1;
  logic       long2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // First enabled step at or after idx; S_WAIT means none left
  function automatic tcs_state_e first_from(input logic [1:0] idx, input logic [2:0] en);
    first_from = S_WAIT;
    if (idx <= 2'h2 && en[2]) begin
      first_from = S_REM2;
    end
    if (idx <= 2'h1 && en[1]) begin
      first_from = S_REM1;
    end
    if (idx == 2'h0 && en[0]) begin
      first_from = S_LOCAL;
    end
  endfunction

  function automatic logic [1:0] chan_of(input tcs_state_e s);
    case (s)
      S_REM1:  chan_of = CH_REM1;
      S_REM2:  chan_of = CH_REM2;
      default: chan_of = CH_LOCAL;
    endcase
  endfunction

  // Remote conversions halve when series correction is off
  function automatic logic [31:0] dur_of(input tcs_state_e s, input logic lng,
                                         input logic rc);
    logic [31:0] d;
    d = lng ? 32'(CONV_AUTO) : 32'(CONV_MANUAL);
    if (!rc) begin
      d = d >> 1;
    end
    dur_of = (s == S_LOCAL) ? 32'(CONV_LOCAL) : d;
  endfunction

  assign chan_en = {DUAL_REMOTE & st_r.chcfg[BIT_REMOTE2_CHAN_EN],
                    st_r.chcfg[BIT_REN1],
                    st_r.chcfg[BIT_LEN]};

  // Start-to-start pass period only; conversion length is never touched by the rate
  assign period_len = (st_r.rate >= RATE_FAST_MIN) ? 32'h0 :
                      32'(PERIOD_FAST) << (RATE_SLOW_SHIFT - st_r.rate[2:0]);

  assign sd_set_wr  = reg_wr_i && (reg_ptr_i == PTR_CFG1_WR) &&
                      reg_wdata_i[BIT_SD] && !st_r.cfg1[BIT_SD];
  assign oneshot_wr = reg_wr_i && (reg_ptr_i == PTR_ONESHOT);

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    st_nxt       = st_r;
    st_nxt.start = 1'b0;
    st_nxt.done  = 1'b0;
    st_nxt.abort = 1'b0;
    go           = 1'b0;
    pass_end     = 1'b0;
    tgt          = S_WAIT;
    if (st_r.period != 32'h0) begin
      st_nxt.period = st_r.period - 32'h1;
    end

    // Register writes
    if (reg_wr_i) begin
      case (reg_ptr_i)
        PTR_CFG1_WR: st_nxt.cfg1 = reg_wdata_i & CFG1_WMASK;
        PTR_RATE_WR: st_nxt.rate = reg_wdata_i;
        PTR_CHCFG:   st_nxt.chcfg = reg_wdata_i & CHCFG_RST;
        default:     st_nxt.rate = st_nxt.rate;
      endcase
    end

    // Sequencer
    case (st_r.state)
      S_SHUT: begin
        if (!st_r.cfg1[BIT_SD]) begin
          go = 1'b1;
        end else if (oneshot_wr) begin
          go             = 1'b1;
          st_nxt.oneshot = 1'b1;
        end
      end
      S_LOCAL, S_REM1, S_REM2: begin
        if (st_r.timer == 32'h0) begin
          st_nxt.done = 1'b1;
          tgt = first_from(chan_of(st_r.state) + 2'h1, chan_en);
          if (tgt == S_WAIT) begin
            pass_end = 1'b1;
          end
        end else begin
          st_nxt.timer = st_r.timer - 32'h1;
        end
      end
      S_WAIT: begin
        if (st_r.period <= 32'h1) begin
          go = 1'b1;
        end
      end
      default: begin
        st_nxt.state = S_SHUT;
      end
    endcase

    if (go) begin
      st_nxt.period = period_len;
      tgt = first_from(2'h0, chan_en);
      if (tgt == S_WAIT) begin
        pass_end = 1'b1;
      end
    end

    if (pass_end) begin
      st_nxt.busy = 1'b0;
      if (st_r.oneshot || st_r.cfg1[BIT_SD] || (go && st_nxt.oneshot)) begin
        st_nxt.state   = S_SHUT;
        st_nxt.oneshot = 1'b0;
      end else begin
        st_nxt.state = S_WAIT;
      end
    end else if (tgt != S_WAIT) begin
      st_nxt.state = tgt;
      st_nxt.start = 1'b1;
      st_nxt.busy  = 1'b1;
      st_nxt.chan  = chan_of(tgt);
      st_nxt.timer = dur_of(tgt, (tgt == S_REM2) ? long2 : long1,
                            st_r.chcfg[BIT_RC]) - 32'h1;
    end

    // Shutdown wins over everything else
    if (sd_set_wr) begin
      st_nxt.state   = S_SHUT;
      st_nxt.abort   = st_r.busy;
      st_nxt.busy    = 1'b0;
      st_nxt.start   = 1'b0;
      st_nxt.done    = 1'b0;
      st_nxt.oneshot = 1'b0;
    end

    // Registered read data
    st_nxt.rvalid = reg_rd_i;
    st_nxt.rdata  = 8'h00;
    if (reg_rd_i) begin
      case (reg_ptr_i)
        PTR_CFG1_RD:  st_nxt.rdata = st_r.cfg1;
        PTR_RATE_RD:  st_nxt.rdata = st_r.rate;
        PTR_CHCFG:    st_nxt.rdata = st_r.chcfg;
        PTR_NADJ1:    st_nxt.rdata = adj1;
        PTR_NADJ_CH2: st_nxt.rdata = DUAL_REMOTE ? adj2 : 8'h00;
        PTR_BETA_CH1: st_nxt.rdata = {4'h0, beta_rd1};
        PTR_BETA_CH2: st_nxt.rdata = DUAL_REMOTE ? {4'h0, beta_rd2} : 8'h00;
        default:      st_nxt.rdata = 8'h00;
      endcase
    end
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      st_r <= '{cfg1: CFG1_RST, chcfg: CHCFG_RST, rate: RATE_RST,
                state: S_SHUT, oneshot: 1'b0, timer: 32'h0, period: 32'h0,
                start: 1'b0, done: 1'b0, abort: 1'b0, busy: 1'b0,
                chan: CH_LOCAL, rdata: 8'h00, rvalid: 1'b0};
    end else begin
      st_r <= st_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Remote channel compensation units
  // ----------------------------------------------------------------
  tcs_chan_comp u_comp1 (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .beta_wr_i   (reg_wr_i && (reg_ptr_i == PTR_BETA_CH1)),
    .adj_wr_i    (reg_wr_i && (reg_ptr_i == PTR_NADJ1)),
    .wdata_i     (reg_wdata_i),
    .start_i     (st_nxt.start && (st_nxt.chan == CH_REM1)),
    .det_diode_i (det_diode1_i),
    .det_range_i (det_range1_i),
    .beta_rd_o   (beta_rd1),
    .adj_o       (adj1),
    .long_conv_o (long1),
    .ni_num_o    (ni_num1_o),
    .ni_den_o    (ni_den1_o)
  );

  tcs_chan_comp u_comp2 (
    .clk_i       (clk_i),
    .rst_i       (rst_i),
    .beta_wr_i   (DUAL_REMOTE && reg_wr_i && (reg_ptr_i == PTR_BETA_CH2)),
    .adj_wr_i    (DUAL_REMOTE && reg_wr_i && (reg_ptr_i == PTR_NADJ_CH2)),
    .wdata_i     (reg_wdata_i),
    .start_i     (st_nxt.start && (st_nxt.chan == CH_REM2)),
    .det_diode_i (det_diode2_i),
    .det_range_i (det_range2_i),
    .beta_rd_o   (beta_rd2),
    .adj_o       (adj2),
    .long_conv_o (long2),
    .ni_num_o    (ni_num2_o),
    .ni_den_o    (ni_den2_o)
  );

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign reg_rdata_o     = st_r.rdata;
  assign reg_rvalid_o    = st_r.rvalid;
  assign conv_start_o    = st_r.start;
  assign conv_done_o     = st_r.done;
  assign conv_abort_o    = st_r.abort;
  assign conv_busy_o     = st_r.busy;
  assign conv_chan_o     = st_r.chan;
  assign series_res_en_o = st_r.chcfg[BIT_RC];
  assign shutdown_o      = st_r.cfg1[BIT_SD];

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  AST_SD_ABORT: assert property (@(posedge clk_i) disable iff (rst_i)
    (sd_set_wr && st_r.busy) |=> (st_r.state == S_SHUT) && conv_abort_o && !conv_busy_o)
    else $error("shutdown did not abort the running conversion");

  AST_ONESHOT_PASS: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.state == S_SHUT && st_r.cfg1[BIT_SD] && oneshot_wr && chan_en != 3'h0)
    |=> conv_start_o && conv_busy_o && st_r.oneshot)
    else $error("one-shot write in shutdown did not start a pass");

  AST_LOCAL_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_start_o && conv_chan_o == CH_LOCAL) |-> $past(st_r.chcfg[BIT_LEN]))
    else $error("disabled local channel was converted");

  AST_REM1_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_start_o && conv_chan_o == CH_REM1) |-> $past(st_r.chcfg[BIT_REN1]))
    else $error("disabled remote channel 1 was converted");

  AST_REM2_EN: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_start_o && conv_chan_o == CH_REM2) |-> DUAL_REMOTE && $past(st_r.chcfg[BIT_REMOTE2_CHAN_EN]))
    else $error("remote channel 2 converted while not enabled");

  AST_ORDER: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_start_o && conv_chan_o == CH_REM1 && $past(st_r.busy))
    |-> $past(st_r.state) == S_LOCAL)
    else $error("remote channel 1 did not follow the local channel");

  AST_SKIP: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.state == S_LOCAL && st_r.timer == 32'h0 && !reg_wr_i && !chan_en[1] && chan_en[2])
    |=> conv_start_o && conv_chan_o == CH_REM2)
    else $error("disabled channel was not skipped");

  AST_FAST_NO_IDLE: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.state == S_WAIT && st_r.rate >= RATE_FAST_MIN && st_r.period == 32'h0
     && chan_en != 3'h0) |=> st_r.state != S_WAIT)
    else $error("fast rate inserted idle time");

  AST_HALF_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_start_o && conv_chan_o == CH_REM1 && !$past(st_r.chcfg[BIT_RC]) && !$past(long1))
    |-> st_r.timer == (32'(CONV_MANUAL) >> 1) - 32'h1)
    else $error("remote conversion length wrong without correction");

  AST_AUTO_TIME: assert property (@(posedge clk_i) disable iff (rst_i)
    (conv_start_o && conv_chan_o == CH_REM1 && $past(st_r.chcfg[BIT_RC]) && $past(long1))
    |-> st_r.timer == 32'(CONV_AUTO) - 32'h1)
    else $error("auto beta conversion length wrong");

  AST_RUN: assert property (@(posedge clk_i) disable iff (rst_i)
    (st_r.state == S_SHUT && !st_r.cfg1[BIT_SD] && !reg_wr_i) |=> st_r.state != S_SHUT)
    else $error("cleared shutdown did not resume converting");

  COV_ROUND: cover property (@(posedge clk_i) disable iff (rst_i)
    conv_start_o && conv_chan_o == CH_REM1 ##[1:1000] conv_done_o);
  COV_ABORT: cover property (@(posedge clk_i) disable iff (rst_i) conv_abort_o);
  COV_ONESHOT: cover property (@(posedge clk_i) disable iff (rst_i)
    st_r.oneshot ##1 (st_r.state == S_SHUT && !st_r.oneshot));

endmodule // tcs_top

/* testbench/tcs_host_model.sv */
// Host model driving the register port of the sequencer
`timescale 1ns/100ps
module tcs_host_model (
  // Clock
  input  wire logic       clk_i,
  // Register port
  output logic            reg_wr_o,
  output logic            reg_rd_o,
  output logic      [7:0] reg_ptr_o,
  output logic      [7:0] reg_wdata_o,
  input  wire logic [7:0] reg_rdata_i,
  input  wire logic       reg_rvalid_i
);
  initial begin
    reg_wr_o = 1'b0;
    reg_rd_o = 1'b0;
    reg_ptr_o = 8'h00;
    reg_wdata_o = 8'h00;
  end
  // Released lines show the inverse of the last value
  task automatic wr(input logic [7:0] p, input logic [7:0] d);
    @(negedge clk_i);
    reg_wr_o = 1'b1;
    reg_ptr_o = p;
    reg_wdata_o = d;
    @(negedge clk_i);
    reg_wr_o = 1'b0;
    reg_ptr_o = ~p;
    reg_wdata_o = ~d;
  endtask
  task automatic rd(input logic [7:0] p, output logic [7:0] d, output logic v);
    @(negedge clk_i);
    reg_rd_o = 1'b1;
    reg_ptr_o = p;
    @(negedge clk_i);
    reg_rd_o = 1'b0;
    reg_ptr_o = ~p;
    d = reg_rdata_i;
    v = reg_rvalid_i;
  endtask
endmodule // tcs_host_model

/* testbench/tb_top.sv */
// Self-checking bench of the temperature conversion sequencer
`timescale 1ns/100ps
module tb_top;
  import tcs_pkg::*;
  localparam int CL = 20, CA = 40, CM = 30, PF = 200;
  logic        clk_i, rst_i, wr, rd, dd1, dd2, rv, st, ab, busy, rc, sd, dn;
  logic [7:0]  ptr, wd, rdat, r;
  logic [2:0]  dr1, dr2;
  logic [1:0]  ch;
  logic [18:0] num1, num2;
  logic [9:0]  den1, den2;
  logic [9:0]  q[$];
  logic [31:0] seed;
  int          n_errors, checks, cyc, gap, i, ndone, n0;
  tcs_host_model host (.clk_i(clk_i), .reg_wr_o(wr), .reg_rd_o(rd), .reg_ptr_o(ptr),
    .reg_wdata_o(wd), .reg_rdata_i(rdat), .reg_rvalid_i(rv));
  tcs_top #(.DUAL_REMOTE(1'b1), .CONV_LOCAL(CL), .CONV_AUTO(CA), .CONV_MANUAL(CM),
    .PERIOD_FAST(PF)) dut (.clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(wr), .reg_rd_i(rd),
    .reg_ptr_i(ptr), .reg_wdata_i(wd), .reg_rdata_o(rdat), .reg_rvalid_o(rv),
    .det_diode1_i(dd1), .det_range1_i(dr1), .det_diode2_i(dd2), .det_range2_i(dr2),
    .conv_start_o(st), .conv_done_o(dn), .conv_abort_o(ab), .conv_busy_o(busy),
    .conv_chan_o(ch), .series_res_en_o(rc), .shutdown_o(sd), .ni_num1_o(num1),
    .ni_den1_o(den1), .ni_num2_o(num2), .ni_den2_o(den2));
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  // ----------------------------------------------------------------
  // Start log: channel and cycles since previous start
  // ----------------------------------------------------------------
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    gap <= (st === 1'b1) ? 1 : gap + 1;
    if (st === 1'b1) q.push_back({ch, 8'(gap)});
    if (dn === 1'b1) ndone <= ndone + 1;
    if (cyc == 20000) begin
      n_errors++;
      finish_test();
    end
  end
  function automatic logic [7:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed[7:0];
  endfunction
  function automatic logic [9:0] nden(input logic [7:0] b);
    return 10'(300 - int'($signed(b)));
  endfunction
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic rdchk(input logic [7:0] p, input logic [7:0] e);
    logic [7:0] d;
    logic       v;
    host.rd(p, d, v);
    chk(v, 1);
    chk(d, e);
  endtask
  task automatic pop(input logic [1:0] c, input int g);
    logic [9:0] e;
    for (int k = 0; k < 1000 && q.size() == 0; k++) @(negedge clk_i);
    e = (q.size() != 0) ? q.pop_front() : 10'h3ff;
    chk(e[9:8], c);
    if (g != 0) chk(e[7:0], g);
  endtask
  task automatic sync(input logic [1:0] c);
    q.delete();
    for (int k = 0; k < 1000 && !(q.size() != 0 && q[0][9:8] === c); k++) begin
      if (q.size() != 0) void'(q.pop_front());
      @(negedge clk_i);
    end
    chk(32'(q.size() != 0), 1);
    if (q.size() != 0) void'(q.pop_front());
  endtask
  task automatic finish_test();
    if (n_errors == 0 && checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    rst_i = 1'b1;
    seed = 32'h4bcfd085;
    n_errors = 0;
    checks = 0;
    dd1 = 1'b0;
    dd2 = 1'b1;
    dr1 = 3'h0;
    dr2 = 3'h0;
    repeat (5) @(negedge clk_i);
    rst_i = 1'b0;
    dr2 = 3'(rnd());
    chk(rc, 1);
    chk(num2, NI_NUM_DIODE);
    rdchk(PTR_RATE_RD, 8'h07);
    rdchk(PTR_CHCFG_DUAL, 8'h3c);
    rdchk(PTR_NADJ_CH1, 8'h00);
    rdchk(PTR_NADJ_CH2, 8'h00);
    rdchk(PTR_ONESHOT, 8'h00);
    rdchk(8'h77, 8'h00);
    sync(CH_LOCAL);
    pop(CH_REM1, CL);
    pop(CH_REM2, CM);
    host.wr(PTR_RATE_WR, 8'h06);
    sync(CH_LOCAL);
    pop(CH_REM1, CL);
    pop(CH_REM2, CM);
    pop(CH_LOCAL, PF - CL - CM);
    host.wr(PTR_CHCFG_DUAL, 8'hf0);
    host.wr(PTR_RATE_WR, 8'h20);
    dr1 = 3'(rnd());
    host.wr(PTR_BETA_CH1, 8'h08);
    rdchk(PTR_CHCFG_DUAL, 8'h30);
    rdchk(PTR_RATE_RD, 8'h20);
    chk(rc, 0);
    sync(CH_REM1);
    pop(CH_REM2, CA / 2);
    pop(CH_REM1, 0);
    chk(num1, NI_NUM_GC);
    rdchk(PTR_BETA_CH1, {5'h01, dr1});
    host.wr(PTR_CFG1_WR, 8'h40);
    for (i = 0; i < 3 && ab !== 1'b1; i++) @(negedge clk_i);
    chk(ab, 1);
    @(negedge clk_i);
    chk(sd, 1);
    chk(busy, 0);
    repeat (200) @(negedge clk_i);
    q.delete();
    n0 = ndone;
    host.wr(PTR_ONESHOT, rnd());
    pop(CH_REM1, 0);
    pop(CH_REM2, CA / 2);
    repeat (100) @(negedge clk_i);
    chk(q.size(), 0);
    chk(busy, 0);
    chk(ndone - n0, 2);
    r = rnd();
    host.wr(PTR_NADJ_CH1, r);
    host.wr(PTR_NADJ_CH2, 8'h80);
    chk(den1, nden(r));
    chk(den2, nden(8'h80));
    rdchk(PTR_NADJ_CH1, r);
    // Local and remote 2 only, continuous at the fast rate
    host.wr(PTR_CHCFG_DUAL, 8'h2c);
    host.wr(PTR_CFG1_WR, 8'h00);
    sync(CH_LOCAL);
    pop(CH_REM2, CL);
    pop(CH_LOCAL, CM + 1);
    // Remote 1 only: auto beta with correction, then manual without
    host.wr(PTR_CHCFG_DUAL, 8'h14);
    sync(CH_REM1);
    pop(CH_REM1, CA + 1);
    host.wr(PTR_BETA_CH1, 8'h07);
    host.wr(PTR_CHCFG_DUAL, 8'h10);
    sync(CH_REM1);
    pop(CH_REM1, CM / 2 + 1);
    chk(num1, NI_NUM_DIODE);
    rdchk(PTR_BETA_CH1, 8'h07);
    finish_test();
  end
endmodule // tb_top
